// ### uarx_defs.vh
// register map, field positions, reset values and bit timing for the receive-path port
`ifndef UARX_DEFS_VH
`define UARX_DEFS_VH
`define UARX_OFS_MODE 8'h00
`define UARX_OFS_STA 8'h04
`define UARX_OFS_TX 8'h08
`define UARX_OFS_RX 8'h0c
`define UARX_OFS_BRG 8'h10
`define UARX_MODE_STOP_COUNT_SELECT 0
`define UARX_MODE_DATA_PARITY_SELECT_LO 1
`define UARX_MODE_DATA_PARITY_SELECT_HI 2
`define UARX_MODE_LOOP 6
`define UARX_MODE_WAKE 7
`define UARX_MODE_HS_LO 8
`define UARX_MODE_HS_HI 9
`define UARX_MODE_EN 15
`define UARX_STA_RXDA 0
`define UARX_STA_OERR 1
`define UARX_STA_FRAMING_ERROR_FLAG 2
`define UARX_STA_PERR 3
`define UARX_STA_RX_SHIFTER_IDLE 4
`define UARX_STA_ADDRESS_MATCH_FILTER_EN 5
`define UARX_STA_ISEL_LO 6
`define UARX_STA_ISEL_HI 7
`define UARX_STA_TXFULL 9
`define UARX_STA_TXEN 10
`define UARX_MODE_RST 16'h0000
`define UARX_STA_WR_RST 16'h0000
`define UARX_BRG_RST 16'h0000
`define UARX_PD_9BIT 2'b11
`define UARX_PD_ODD 2'b10
`define UARX_PD_NONE 2'b00
`define UARX_HS_NONE 2'b00
`define UARX_HS_RTS 2'b01
`define UARX_HS_FLOW 2'b10
`define UARX_HS_BCLK 2'b11
`define UARX_SAMPLE_TICK 4'h7
`define UARX_FIFO_DEPTH 3'h4
`endif

// ### uarx_baud.v
// 16x baud tick divider
`timescale 1ns/100ps
`include "uarx_defs.vh"
module uarx_baud (
	input wire clk_i,
	input wire rst_i,
	input wire en_i,
	input wire [15:0] div_i,
	output reg tick_o
);
	reg [15:0] cnt_q;

	// tick once every div_i+1 cycles; divider zero gives a tick every cycle
	always @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt_q <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt_q >= div_i) begin
			cnt_q <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule // uarx_baud

// ### uarx_tx.v
// frame transmitter: start, 8 or 9 data bits, optional parity, one or two stop bits
`timescale 1ns/100ps
`include "uarx_defs.vh"
module uarx_tx (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire start_i,
	input wire [8:0] data_i,
	input wire [1:0] data_parity_select_i,
	input wire two_stop_i,
	output reg line_o,
	output reg busy_o
);
	reg [11:0] frame_q;
	reg [3:0] left_q;
	reg [3:0] cnt_q;
	wire par_bit;

	// even parity for 01, odd parity for 10
	assign par_bit = (^data_i[7:0]) ^ (data_parity_select_i == `UARX_PD_ODD);

	// frame bits shift out lsb first after the start bit; line idles high
	always @(posedge clk_i) begin
		if (rst_i) begin
			frame_q <= 12'hfff;
			left_q <= 4'h0;
			cnt_q <= 4'h0;
			line_o <= 1'b1;
			busy_o <= 1'b0;
		end else if (!busy_o) begin
			if (start_i) begin
				busy_o <= 1'b1;
				line_o <= 1'b0;
				cnt_q <= 4'h0;
				if (data_parity_select_i == `UARX_PD_9BIT) begin
					frame_q <= {3'b111, data_i};
				end else if (data_parity_select_i == `UARX_PD_NONE) begin
					frame_q <= {4'b1111, data_i[7:0]};
				end else begin
					frame_q <= {3'b111, par_bit, data_i[7:0]};
				end
				left_q <= (data_parity_select_i == `UARX_PD_NONE)
					? (two_stop_i ? 4'ha : 4'h9) : (two_stop_i ? 4'hb : 4'ha);
			end
		end else if (tick_i) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'hf) begin
				if (left_q == 4'h0) begin
					busy_o <= 1'b0;
					line_o <= 1'b1;
				end else begin
					line_o <= frame_q[0];
					frame_q <= {1'b1, frame_q[11:1]};
					left_q <= left_q - 4'h1;
				end
			end
		end
	end
endmodule // uarx_tx

// ### uarx_top.v
// serial port with address filtering, break reception and internal loopback
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "uarx_defs.vh"
module uarx_top (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire serial_in_pin_i,
	output reg serial_out_pin_o,
	input wire clear_to_send_in_n_i,
	output reg request_to_send_out_n_o,
	output reg baud_x16_clock_out_o,
	output reg rx_event_o
);
	localparam ST_IDLE = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_PAR = 3'h3;
	localparam ST_STOP = 3'h4;
	localparam ST_STOP2 = 3'h5;
	localparam ST_HOLD = 3'h6;

	reg [15:0] mode_q;
	reg [15:0] sta_q;
	reg [15:0] brg_q;
	reg [8:0] txbuf_q;
	reg tx_full_q;
	reg [10:0] fifo_mem [0:3];
	reg [1:0] wr_ptr_q;
	reg [1:0] rd_ptr_q;
	reg [2:0] count_q;
	reg [2:0] state_q;
	reg [3:0] cnt_q;
	reg [3:0] idx_q;
	reg [8:0] shift_q;
	reg stop_low_q;
	reg perr_q;
	reg oerr_q;
	integer i;

	wire tick;
	wire tx_line;
	wire tx_busy;
	wire en = mode_q[`UARX_MODE_EN];
	wire loop = mode_q[`UARX_MODE_LOOP];
	wire [1:0] data_parity_select =
		mode_q[`UARX_MODE_DATA_PARITY_SELECT_HI:`UARX_MODE_DATA_PARITY_SELECT_LO];
	wire [1:0] hs = mode_q[`UARX_MODE_HS_HI:`UARX_MODE_HS_LO];
	wire [1:0] isel = sta_q[`UARX_STA_ISEL_HI:`UARX_STA_ISEL_LO];
	wire address_match_filter_en = sta_q[`UARX_STA_ADDRESS_MATCH_FILTER_EN];
	wire nine = (data_parity_select == `UARX_PD_9BIT);
	wire par_en = (data_parity_select != `UARX_PD_NONE) && !nine;
	wire two_stop = mode_q[`UARX_MODE_STOP_COUNT_SELECT];
	wire [3:0] last_idx = nine ? 4'h8 : 4'h7;
	// in loopback the receive pin is cut off; the transmit pin still drives
	wire rx_line = loop ? tx_line : serial_in_pin_i;
	// in loopback internal cts follows rts in every config; only config 10 looks at it
	wire cts_n_int = loop ? request_to_send_out_n_o : clear_to_send_in_n_i;
	wire cts_ok = (hs == `UARX_HS_FLOW) ? !cts_n_int : 1'b1;
	wire tx_start = en && sta_q[`UARX_STA_TXEN] && tx_full_q && !tx_busy && cts_ok;
	wire sample = tick && (cnt_q == `UARX_SAMPLE_TICK);
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire bus_wr = bus_req && wb_we_i;
	wire [2:0] reg_sel = decode(wb_adr_i);
	wire pop = bus_req && !wb_we_i && (reg_sel == 3'h4) && (count_q != 3'h0);
	wire [10:0] top_word = fifo_mem[rd_ptr_q];

	// register index from byte address; 0 means unmapped
	function [2:0] decode;
		input [7:0] adr;
		begin
			case (adr)
				`UARX_OFS_MODE: decode = 3'h1;
				`UARX_OFS_STA: decode = 3'h2;
				`UARX_OFS_TX: decode = 3'h3;
				`UARX_OFS_RX: decode = 3'h4;
				`UARX_OFS_BRG: decode = 3'h5;
				default: decode = 3'h0;
			endcase
		end
	endfunction

	// byte-lane merge for the 16-bit registers
	function [15:0] merge;
		input [15:0] old;
		input [31:0] dat;
		input [3:0] sel;
		begin
			merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
		end
	endfunction

	// end-of-frame decisions, taken when the last stop bit is sampled
	reg frame_done;
	reg frame_bad_stop;
	reg drop;
	reg push;
	reg set_oerr;
	reg fire;
	reg [2:0] cnt_after;
	always @* begin
		frame_done = 1'b0;
		if (sample && ((state_q == ST_STOP && !two_stop) || state_q == ST_STOP2)) begin
			frame_done = 1'b1;
		end
		frame_bad_stop = stop_low_q || !rx_line;
		drop = nine && address_match_filter_en && !shift_q[8];
		push = frame_done && !drop && !oerr_q && (count_q != `UARX_FIFO_DEPTH);
		set_oerr = frame_done && !drop && (count_q == `UARX_FIFO_DEPTH);
		cnt_after = count_q + 3'h1;
		case (isel)
			2'b00: fire = 1'b1;
			2'b01: fire = 1'b1;
			2'b10: fire = (cnt_after >= 3'h3);
			2'b11: fire = (cnt_after == `UARX_FIFO_DEPTH);
			default: fire = 1'b1;
		endcase
	end

	uarx_baud u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(en),
		.div_i(brg_q),
		.tick_o(tick)
	);

	uarx_tx u_tx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.start_i(tx_start),
		.data_i(txbuf_q),
		.data_parity_select_i(data_parity_select),
		.two_stop_i(two_stop),
		.line_o(tx_line),
		.busy_o(tx_busy)
	);

	// receive shifter; all counting is in 16x ticks, sampling mid bit
	always @(posedge clk_i) begin
		if (rst_i || !en) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			idx_q <= 4'h0;
			shift_q <= 9'h000;
			stop_low_q <= 1'b0;
			perr_q <= 1'b0;
		end else if (tick) begin
			cnt_q <= cnt_q + 4'h1;
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 4'h0;
					if (!rx_line) begin
						state_q <= ST_START;
					end
				end
				ST_START: begin
					// a glitch shorter than half a bit is not a start
					if (sample) begin
						state_q <= rx_line ? ST_IDLE : ST_DATA;
						idx_q <= 4'h0;
						shift_q <= 9'h000;
						stop_low_q <= 1'b0;
						perr_q <= 1'b0;
					end
				end
				ST_DATA: begin
					if (sample) begin
						shift_q[idx_q] <= rx_line;
						idx_q <= idx_q + 4'h1;
						if (idx_q == last_idx) begin
							state_q <= par_en ? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: begin
					if (sample) begin
						perr_q <= (^shift_q[7:0]) ^ rx_line
							^ (data_parity_select == `UARX_PD_ODD);
						state_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (sample) begin
						stop_low_q <= !rx_line;
						if (two_stop) begin
							state_q <= ST_STOP2;
						end
					end
				end
				ST_STOP2: begin
				end
				ST_HOLD: begin
					// wake mode: the low line is not taken as the next start
					if (rx_line) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			// a long break also ends here, after the programmed frame length
			if (frame_done) begin
				if (frame_bad_stop && mode_q[`UARX_MODE_WAKE]) begin
					state_q <= ST_HOLD;
				end else begin
					state_q <= ST_IDLE;
				end
			end
		end
	end

	// receive fifo; clearing the overrun flag empties it
	always @(posedge clk_i) begin
		if (rst_i || (bus_wr && reg_sel == 3'h2 && wb_sel_i[0]
			&& !wb_dat_i[`UARX_STA_OERR] && oerr_q)) begin
			wr_ptr_q <= 2'h0;
			rd_ptr_q <= 2'h0;
			count_q <= 3'h0;
			for (i = 0; i < 4; i = i + 1) begin
				fifo_mem[i] <= 11'h000;
			end
		end else begin
			if (push) begin
				// break arrives here as all zeros with the framing flag
				fifo_mem[wr_ptr_q] <= {perr_q, frame_bad_stop, shift_q};
				wr_ptr_q <= wr_ptr_q + 2'h1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 2'h1;
			end
			if (push && !pop) begin
				count_q <= count_q + 3'h1;
			end else if (pop && !push) begin
				count_q <= count_q - 3'h1;
			end
		end
	end

	// control registers; the overrun set beats a same-cycle software clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= `UARX_MODE_RST;
			sta_q <= `UARX_STA_WR_RST;
			brg_q <= `UARX_BRG_RST;
			txbuf_q <= 9'h000;
			tx_full_q <= 1'b0;
			oerr_q <= 1'b0;
		end else begin
			if (tick && state_q == ST_HOLD && rx_line && shift_q == 9'h000) begin
				mode_q[`UARX_MODE_WAKE] <= 1'b0;
			end
			if (tx_start) begin
				tx_full_q <= 1'b0;
			end
			if (bus_wr && reg_sel == 3'h1) begin
				mode_q <= merge(mode_q, wb_dat_i, wb_sel_i);
			end
			if (bus_wr && reg_sel == 3'h2) begin
				sta_q <= merge(sta_q, wb_dat_i, wb_sel_i);
				if (wb_sel_i[0] && !wb_dat_i[`UARX_STA_OERR]) begin
					oerr_q <= 1'b0;
				end
			end
			if (bus_wr && reg_sel == 3'h3) begin
				// a write while a word waits replaces it
				txbuf_q <= wb_dat_i[8:0];
				tx_full_q <= 1'b1;
			end
			if (bus_wr && reg_sel == 3'h5) begin
				brg_q <= merge(brg_q, wb_dat_i, wb_sel_i);
			end
			if (set_oerr && tick) begin
				oerr_q <= 1'b1;
			end
		end
	end

	// wishbone answer: ack one cycle after the request, read data with it
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h00000000;
			if (bus_req && !wb_we_i) begin
				case (reg_sel)
					3'h1: wb_dat_o <= {16'h0000, mode_q};
					3'h2: wb_dat_o <= {16'h0000, 5'h00, sta_q[`UARX_STA_TXEN],
						tx_full_q, 1'b0, isel, address_match_filter_en,
						state_q == ST_IDLE, top_word[10], top_word[9],
						oerr_q, count_q != 3'h0};
					3'h3: wb_dat_o <= {23'h0, txbuf_q};
					3'h4: wb_dat_o <= {23'h0, top_word[8:0]};
					3'h5: wb_dat_o <= {16'h0000, brg_q};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// pins and receive event, all registered
	always @(posedge clk_i) begin
		if (rst_i) begin
			serial_out_pin_o <= 1'b1;
			request_to_send_out_n_o <= 1'b1;
			baud_x16_clock_out_o <= 1'b0;
			rx_event_o <= 1'b0;
		end else begin
			serial_out_pin_o <= tx_line;
			// rts asks for data while the fifo has room; inactive in configs 00 and 11
			if (en && (hs == `UARX_HS_RTS || hs == `UARX_HS_FLOW)) begin
				request_to_send_out_n_o <= (count_q == `UARX_FIFO_DEPTH);
			end else begin
				request_to_send_out_n_o <= 1'b1;
			end
			if (hs == `UARX_HS_BCLK && en) begin
				if (tick) begin
					baud_x16_clock_out_o <= !baud_x16_clock_out_o;
				end
			end else begin
				baud_x16_clock_out_o <= 1'b0;
			end
			rx_event_o <= push && tick && fire;
		end
	end
endmodule // uarx_top

// ### uarx_sva.sv
// bus-side and pin-side assertions for the serial port top
`timescale 1ns/100ps
module uarx_sva (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire request_to_send_out_n_o,
	input wire baud_x16_clock_out_o,
	input wire rx_event_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reg [15:0] mode_q;
	reg filter_en_q;
	reg rd_mode_q;
	reg rd_sta_q;
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [1:0] hs = mode_q[9:8];
	// shadow of written mode and filter bits, updated on bus writes; the port's own wake-bit clear is not mirrored
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= 16'h0000;
			filter_en_q <= 1'b0;
			rd_mode_q <= 1'b0;
			rd_sta_q <= 1'b0;
		end else if (take) begin
			rd_mode_q <= !wb_we_i && wb_adr_i == 8'h00;
			rd_sta_q <= !wb_we_i && wb_adr_i == 8'h04;
			if (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
				mode_q[7:0] <= wb_dat_i[7:0];
			if (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1])
				mode_q[15:8] <= wb_dat_i[15:8];
			if (wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0])
				filter_en_q <= wb_dat_i[5];
		end
	end
	AST_ACK_NEXT: assert property (take |=> wb_ack_o) else $error("request not acked");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	AST_FILTER_RB: assert property (wb_ack_o && rd_sta_q |-> wb_dat_o[5] == filter_en_q)
		else $error("filter enable readback wrong");
	AST_DATA_PARITY_SELECT_RB: assert property (wb_ack_o && rd_mode_q |-> wb_dat_o[2:1] == mode_q[2:1])
		else $error("data select readback wrong");
	AST_LOOP_RB: assert property (wb_ack_o && rd_mode_q |-> wb_dat_o[6] == mode_q[6])
		else $error("loop bit readback wrong");
	AST_EVT_PULSE: assert property (rx_event_o |=> !rx_event_o) else $error("event not a pulse");
	AST_BCLK_OFF: assert property (hs != 2'b11 && $past(hs) != 2'b11 |-> !baud_x16_clock_out_o)
		else $error("baud clock out active");
	AST_RTS_OFF: assert property ((hs == 2'b00 || hs == 2'b11) &&
		($past(hs) == 2'b00 || $past(hs) == 2'b11) |-> request_to_send_out_n_o)
		else $error("rts active while unused");
endmodule // uarx_sva
bind uarx_top uarx_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.request_to_send_out_n_o(request_to_send_out_n_o),
	.baud_x16_clock_out_o(baud_x16_clock_out_o), .rx_event_o(rx_event_o));

// ### uarx_node.sv
// remote serial node that drives the port's receive line
`timescale 1ns/100ps
module uarx_node #(parameter int BIT_CLKS = 16) (
	input wire logic clk_i,
	output logic line_o
);
	// line is high whenever no frame or break is sent
	initial line_o = 1'b1;
	// start, n data bits lsb first, one high stop bit
	task automatic frame(input logic [8:0] d, input int n);
		logic [10:0] f;
		f = {2'b11, d} << 1;
		f[n + 1] = 1'b1;
		for (int i = 0; i < n + 2; i++) begin
			@(posedge clk_i);
			line_o <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
	endtask
	// break: line held low for a number of clocks, then released high
	task automatic brk(input int clks);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (clks) @(posedge clk_i);
		line_o <= 1'b1;
	endtask
endmodule // uarx_node

// ### uarx_top_tb_top.sv
// self-checking testbench for the serial port receive features
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module uarx_top_tb_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ser_in, ser_out;
	logic cts_n, rts_n, bclk, rx_event_o, bclk_seen, tx_low;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [8:0] d;
	logic [63:0] exp_q[$];
	int fails = 0, total_checks = 0, ev_cnt = 0, cyc_n = 0;
	uarx_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in_pin_i(ser_in),
		.serial_out_pin_o(ser_out), .clear_to_send_in_n_i(cts_n),
		.request_to_send_out_n_o(rts_n), .baud_x16_clock_out_o(bclk), .rx_event_o(rx_event_o));
	uarx_node u_node (.clk_i(clk_i), .line_o(ser_in));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// event tally, pin activity flags and hang guard
	always @(posedge clk_i) begin
		cyc_n++;
		if (rx_event_o) ev_cnt++;
		if (bclk) bclk_seen = 1'b1;
		if (!ser_out) tx_low = 1'b1;
		if (cyc_n == 20000) begin
			fails++;
			end_of_test();
		end
	end
	// read answers are matched against the oldest noted expectation
	always @(posedge clk_i) begin
		if (wb_ack_o && !wb_we_i) begin
			`CHK(wb_dat_o & exp_q[0][63:32], exp_q[0][31:0])
			void'(exp_q.pop_front());
		end
	end
	// one classic cycle, held until ack is sampled high
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= v;
		wb_sel_i <= 4'h3;
		do begin
			@(posedge clk_i);
			n++;
		end while (!wb_ack_o && n < 50);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n == 50) fails++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		exp_q.push_back({m, v});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic end_of_test();
		if (fails == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		{rst_i, cts_n} = 2'b11;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		void'($urandom(93));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// 9-bit words with address filtering; the filtered data word raises no event
		wr(8'h00, 32'h8006);
		wr(8'h04, 32'h0420);
		rd(8'h04, 32'h20, 32'h20);
		d = 9'($urandom);
		u_node.frame({1'b0, d[7:0]}, 9);
		u_node.frame({1'b1, d[7:0]}, 9);
		nap(4);
		`CHK(ev_cnt, 1)
		rd(8'h0c, 32'h1ff, {23'h0, 1'b1, d[7:0]});
		wr(8'h04, 32'h0400);
		u_node.frame({1'b0, ~d[7:0]}, 9);
		nap(4);
		rd(8'h0c, 32'h1ff, {24'h0, ~d[7:0]});
		// filter request has no effect on 8-bit words
		wr(8'h04, 32'h0420);
		wr(8'h00, 32'h8000);
		d = 9'($urandom);
		u_node.frame(d, 8);
		nap(4);
		rd(8'h0c, 32'h1ff, {24'h0, d[7:0]});
		// break without wake is one zero word with framing error
		u_node.brk(156);
		nap(40);
		rd(8'h04, 32'h15, 32'h15);
		rd(8'h0c, 32'h1ff, 32'h0);
		rd(8'h04, 32'h1, 32'h0);
		// break with wake: receiver holds off until the line is high again
		wr(8'h00, 32'h8080);
		fork
			u_node.brk(224);
			begin
				nap(200);
				rd(8'h04, 32'h15, 32'h05);
			end
		join
		nap(30);
		rd(8'h00, 32'h80, 32'h0);
		rd(8'h04, 32'h15, 32'h15);
		rd(8'h0c, 32'h1ff, 32'h0);
		rd(8'h04, 32'h1, 32'h0);
		`CHK(ev_cnt, 5)
		// loopback in every handshake setting, with the pin held low
		wr(8'h04, 32'h0440);
		for (int h = 0; h < 4; h++) begin
			d = 9'($urandom);
			wr(8'h00, 32'h8000 | (h << 8));
			wr(8'h00, 32'h8040 | (h << 8));
			bclk_seen = 1'b0;
			tx_low = 1'b0;
			fork
				u_node.brk(300);
				begin
					wr(8'h08, {24'h0, d[7:0]});
					nap(220);
				end
			join
			rd(8'h0c, 32'h1ff, {24'h0, d[7:0]});
			`CHK(tx_low, 1'b1)
			`CHK(rts_n, (h == 1 || h == 2) ? 1'b0 : 1'b1)
			`CHK(bclk_seen, h == 3)
		end
		`CHK(ev_cnt, 9)
		// even parity and two stops; one event when the fifo fills, then overrun
		wr(8'h00, 32'h8003);
		wr(8'h04, 32'h04c0);
		d = 9'($urandom);
		u_node.frame({~^d[7:0], d[7:0]}, 9);
		for (int k = 0; k < 4; k++) begin
			nap(20);
			u_node.frame({^d[7:0], d[7:0]}, 9);
		end
		nap(20);
		`CHK(ev_cnt, 10)
		rd(8'h04, 32'hf, 32'hb);
		rd(8'h0c, 32'h1ff, {24'h0, d[7:0]});
		// writing overrun low flushes the fifo
		wr(8'h04, 32'h04c0);
		rd(8'h04, 32'h3, 32'h0);
		end_of_test();
	end
endmodule // uarx_top_tb_top
